// ---- verilog/phy_power_regs.svh ----
// register offsets, field positions and timing for phy power control
`ifndef PHY_POWER_REGS_SVH
`define PHY_POWER_REGS_SVH

`define ADDR_W          8
`define DATA_W          16
`define OFS_PWR_EVENT   8'hD4
`define OFS_SLEEP_WAKE  8'hD6
`define OFS_PHY_RESET   8'hD8
`define OFS_BASIC_CTL   8'hE4
`define OFS_BASIC_STAT  8'hE6
`define OFS_PORT_CTL    8'hF6
`define OFS_PORT_STAT   8'hF8

`define PM_MODE_LSB     0
`define PM_MODE_MSB     1
`define PM_AUTO_WAKE    7
`define PMODE_NORMAL    2'h0
`define PMODE_ENERGY    2'h1
`define PMODE_SAVING    2'h3

`define SW_WAKE_LSB     8
`define SW_WAKE_MSB     15
`define SW_SLEEP_LSB    0
`define SW_SLEEP_MSB    7
`define SW_WAKE_RST     8'h08
`define SW_SLEEP_RST    8'h0C
`define WAKE_UNIT_MS    16
`define SLEEP_UNIT_S    1
`define MS_PER_S        1000

`define RST_PHY_BIT     0

`define CTL_LOOPBACK    14
`define CTL_FORCE100    13
`define CTL_AN_ENABLE   12
`define CTL_AN_RESTART  9
`define CTL_FULL_DUPLEX 8
`define CTL_XOVER_ALG   5
`define CTL_FORCE_MDIX  4
`define CTL_DIS_MDIX    3
`define CTL_DIS_TX      1
`define CTL_DIS_LED     0

`define PC_FULL_DUPLEX  5
`define PC_FORCE100     6
`define PC_AN_ENABLE    7
`define PC_FORCE_MDIX   9
`define PC_DIS_MDIX     10
`define PC_AN_RESTART   13
`define PC_DIS_TX       14
`define PC_DIS_LED      15
`define PS_XOVER_ALG    15
`define PS_AN_DONE      6
`define PS_LINK         5

`define ST_T4           15
`define ST_CAP_LSB      11
`define ST_CAP_MSB      14
`define ST_CAP_ALL      4'hF
`define ST_AN_DONE      5
`define ST_AN_CAP       3
`define ST_LINK         2
`define ST_EXTENDED     0

`define CLK_PERIOD_NS   8
`define NS_PER_MS       1000000
`define TGT_W           18

`endif

// ---- verilog/phy_power_pkg.sv ----
// types shared by the phy power control block
package phy_power_pkg;
  // gray order: normal, awake, asleep, saving
  typedef enum logic [1:0] {
    PWR_NORMAL    = 2'h0,
    PWR_ED_AWAKE  = 2'h1,
    PWR_ED_ASLEEP = 2'h3,
    PWR_SAVING    = 2'h2
  } pwr_state_t;
endpackage

// ---- verilog/sustain_timer.sv ----
// counts how long a condition has held without a break
`timescale 1ns/1ns
module sustain_timer #(
  parameter int W = 18
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_tick,
  input  wire logic         i_cond,
  input  wire logic         i_clear,
  input  wire logic [W-1:0] i_target,
  output logic              o_expired
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic         at_target;

  assign at_target = (count_q >= i_target);
  assign count_d = (i_clear || !i_cond) ? '0 :
                   (i_tick && !at_target) ? count_q + 1'b1 :
                   count_q;
  // clear only restarts the count; keeping it out of the expiry
  // avoids a loop through the caller's next-state logic
  assign o_expired = i_cond && at_target;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule

// ---- verilog/phy_power_control_regs.sv ----
// phy power, reset and basic control/status register group
// Functional notes
// - mode 00 normal, 01 energy detect with sleep/awake, 11 power saving
// - any host register access wakes energy detect low-power state
// - wake time bits 15-8, 16 ms units, reset 0x08
// - writing one to reset bit 0 pulses phy reset, reads zero
// - control bit 14 loops host frames back through the phy
// - bit 12 autoneg enable; bit 13 forces 100 or 10 otherwise
// - writing one to control bit 9 restarts autoneg
// - control bit 8 forces full or half duplex
// - bit 5 crossover algorithm, bit 4 force cross, bit 3 disable
// - control bit 1 disables the transmitter
// - control bit 0 turns off all indicator leds
// - shared control bits visible through port control registers too, crossover algorithm through port status bit 15
// - capability status bits fixed: 14-11 and 3 one, 15 and 0 zero
// - status bit 5 shows autoneg complete, mirrors port status
// - status bit 2 shows link up, mirrors port status
// - automatic wake only when auto wake-up bit 7 is set
`timescale 1ns/1ns
`include "phy_power_regs.svh"
module phy_power_control_regs #(
  parameter int MS_CYCLES = `NS_PER_MS / `CLK_PERIOD_NS
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  input  wire logic [`ADDR_W-1:0]        i_reg_addr,
  input  wire logic [`DATA_W-1:0]        i_reg_wdata,
  input  wire logic [1:0]                i_reg_be,
  input  wire logic                      i_energy_detect,
  input  wire logic                      i_link_up,
  input  wire logic                      i_an_complete,
  output logic [`DATA_W-1:0]             o_reg_rdata,
  output logic                           o_reg_rvalid,
  output phy_power_pkg::pwr_state_t      o_power_state,
  output logic                           o_low_power,
  output logic                           o_phy_reset,
  output logic                           o_loopback,
  output logic                           o_force_100,
  output logic                           o_an_enable,
  output logic                           o_an_restart,
  output logic                           o_full_duplex,
  output logic                           o_xover_alg,
  output logic                           o_force_mdix,
  output logic                           o_disable_mdix,
  output logic                           o_tx_disable,
  output logic                           o_led_disable
);
  import phy_power_pkg::*;

  // ---------------------------------------------
  // reset release and energy synchroniser
  // ---------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic       energy_meta_q;
  logic       energy_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      energy_meta_q <= 1'b0;
      energy_q      <= 1'b0;
    end else begin
      energy_meta_q <= i_energy_detect;
      energy_q      <= energy_meta_q;
    end
  end

  // ---------------------------------------------
  // millisecond tick divider
  // ---------------------------------------------
  localparam int DIV_W = $clog2(MS_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);
  logic [DIV_W-1:0] div_q;
  logic             tick_q;
  logic             div_wrap;

  assign div_wrap = (div_q == DIV_LAST);

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_wrap ? '0 : div_q + 1'b1;
      tick_q <= div_wrap;
    end
  end

  // ---------------------------------------------
  // address decode
  // ---------------------------------------------
  logic hit_pm;
  logic hit_sw;
  logic hit_rst;
  logic hit_ctl;
  logic hit_stat;
  logic hit_pc;
  logic hit_ps;
  logic wr_pm_lo;
  logic wr_sw_lo;
  logic wr_sw_hi;
  logic wr_rst_lo;
  logic wr_ctl_lo;
  logic wr_ctl_hi;
  logic wr_pc_lo;
  logic wr_pc_hi;
  logic wr_ps_hi;
  logic host_access;

  assign hit_pm    = (i_reg_addr == `OFS_PWR_EVENT);
  assign hit_sw    = (i_reg_addr == `OFS_SLEEP_WAKE);
  assign hit_rst   = (i_reg_addr == `OFS_PHY_RESET);
  assign hit_ctl   = (i_reg_addr == `OFS_BASIC_CTL);
  assign hit_stat  = (i_reg_addr == `OFS_BASIC_STAT);
  assign hit_pc    = (i_reg_addr == `OFS_PORT_CTL);
  assign hit_ps    = (i_reg_addr == `OFS_PORT_STAT);
  assign wr_pm_lo  = i_reg_wr && hit_pm  && i_reg_be[0];
  assign wr_sw_lo  = i_reg_wr && hit_sw  && i_reg_be[0];
  assign wr_sw_hi  = i_reg_wr && hit_sw  && i_reg_be[1];
  assign wr_rst_lo = i_reg_wr && hit_rst && i_reg_be[0];
  assign wr_ctl_lo = i_reg_wr && hit_ctl && i_reg_be[0];
  assign wr_ctl_hi = i_reg_wr && hit_ctl && i_reg_be[1];
  assign wr_pc_lo  = i_reg_wr && hit_pc  && i_reg_be[0];
  assign wr_pc_hi  = i_reg_wr && hit_pc  && i_reg_be[1];
  assign wr_ps_hi  = i_reg_wr && hit_ps  && i_reg_be[1];
  assign host_access = i_reg_wr || i_reg_rd;

  // ---------------------------------------------
  // power event and timing registers
  // ---------------------------------------------
  logic [1:0] pmode_q;
  logic       auto_wake_q;
  logic [7:0] wake_q;
  logic [7:0] sleep_q;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pmode_q     <= `PMODE_NORMAL;
      auto_wake_q <= 1'b0;
      wake_q      <= `SW_WAKE_RST;
      sleep_q     <= `SW_SLEEP_RST;
    end else begin
      if (wr_pm_lo) begin
        pmode_q     <= i_reg_wdata[`PM_MODE_MSB:`PM_MODE_LSB];
        auto_wake_q <= i_reg_wdata[`PM_AUTO_WAKE];
      end
      if (wr_sw_hi) begin
        wake_q <= i_reg_wdata[`SW_WAKE_MSB:`SW_WAKE_LSB];
      end
      if (wr_sw_lo) begin
        sleep_q <= i_reg_wdata[`SW_SLEEP_MSB:`SW_SLEEP_LSB];
      end
    end
  end

  // ---------------------------------------------
  // basic / port control bits (loopback basic only) and phy reset
  // ---------------------------------------------
  logic loop_d;
  logic f100_d;
  logic an_en_d;
  logic fdx_d;
  logic xalg_d;
  logic fmdix_d;
  logic dmdix_d;
  logic txdis_d;
  logic leddis_d;
  logic restart_d;
  logic phy_rst_d;

  assign loop_d = wr_ctl_hi ? i_reg_wdata[`CTL_LOOPBACK] : o_loopback;
  // either location writes the same bit
  assign f100_d = wr_ctl_hi ? i_reg_wdata[`CTL_FORCE100] :
                  wr_pc_lo  ? i_reg_wdata[`PC_FORCE100]  : o_force_100;
  assign an_en_d = wr_ctl_hi ? i_reg_wdata[`CTL_AN_ENABLE] :
                   wr_pc_lo  ? i_reg_wdata[`PC_AN_ENABLE]  : o_an_enable;
  assign fdx_d = wr_ctl_hi ? i_reg_wdata[`CTL_FULL_DUPLEX] :
                 wr_pc_lo  ? i_reg_wdata[`PC_FULL_DUPLEX]  : o_full_duplex;
  assign xalg_d = wr_ctl_lo ? i_reg_wdata[`CTL_XOVER_ALG] :
                  wr_ps_hi  ? i_reg_wdata[`PS_XOVER_ALG]  : o_xover_alg;
  assign fmdix_d = wr_ctl_lo ? i_reg_wdata[`CTL_FORCE_MDIX] :
                   wr_pc_hi  ? i_reg_wdata[`PC_FORCE_MDIX]  : o_force_mdix;
  assign dmdix_d = wr_ctl_lo ? i_reg_wdata[`CTL_DIS_MDIX] :
                   wr_pc_hi  ? i_reg_wdata[`PC_DIS_MDIX]  : o_disable_mdix;
  assign txdis_d = wr_ctl_lo ? i_reg_wdata[`CTL_DIS_TX] :
                   wr_pc_hi  ? i_reg_wdata[`PC_DIS_TX]  : o_tx_disable;
  assign leddis_d = wr_ctl_lo ? i_reg_wdata[`CTL_DIS_LED] :
                    wr_pc_hi  ? i_reg_wdata[`PC_DIS_LED]  : o_led_disable;
  // restart pulse, bit reads back zero
  assign restart_d = (wr_ctl_hi && i_reg_wdata[`CTL_AN_RESTART]) ||
                     (wr_pc_hi && i_reg_wdata[`PC_AN_RESTART]);
  assign phy_rst_d = wr_rst_lo && i_reg_wdata[`RST_PHY_BIT];

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_loopback     <= 1'b0;
      o_force_100    <= 1'b1;
      o_an_enable    <= 1'b1;
      o_full_duplex  <= 1'b1;
      o_xover_alg    <= 1'b1;
      o_force_mdix   <= 1'b0;
      o_disable_mdix <= 1'b0;
      o_tx_disable   <= 1'b0;
      o_led_disable  <= 1'b0;
      o_an_restart   <= 1'b0;
      o_phy_reset    <= 1'b0;
    end else begin
      o_loopback     <= loop_d;
      o_force_100    <= f100_d;
      o_an_enable    <= an_en_d;
      o_full_duplex  <= fdx_d;
      o_xover_alg    <= xalg_d;
      o_force_mdix   <= fmdix_d;
      o_disable_mdix <= dmdix_d;
      o_tx_disable   <= txdis_d;
      o_led_disable  <= leddis_d;
      o_an_restart   <= restart_d;
      o_phy_reset    <= phy_rst_d;
    end
  end

  // ---------------------------------------------
  // energy detect state machine
  // ---------------------------------------------
  pwr_state_t          state_d;
  logic                timer_cond;
  logic                timer_clear;
  logic                timer_exp;
  logic [`TGT_W-1:0]   timer_target;
  logic [`TGT_W-1:0]   wake_ms;
  logic [`TGT_W-1:0]   sleep_ms;
  logic                asleep;

  assign asleep   = (o_power_state == PWR_ED_ASLEEP);
  assign wake_ms  = `TGT_W'(wake_q) * `TGT_W'(`WAKE_UNIT_MS);
  assign sleep_ms = `TGT_W'(sleep_q) *
                    `TGT_W'(`SLEEP_UNIT_S * `MS_PER_S);
  // energy wakes from sleep; lack of energy puts to sleep
  assign timer_cond   = asleep ? energy_q : !energy_q;
  assign timer_target = asleep ? wake_ms : sleep_ms;
  assign timer_clear  = (state_d != o_power_state) ||
                        (pmode_q != `PMODE_ENERGY);

  sustain_timer #(
    .W (`TGT_W)
  ) u_timer (
    .i_clk     (i_core_clk),
    .i_rst_n   (rst_n),
    .i_tick    (tick_q),
    .i_cond    (timer_cond),
    .i_clear   (timer_clear),
    .i_target  (timer_target),
    .o_expired (timer_exp)
  );

  always_comb begin
    state_d = o_power_state;
    case (pmode_q)
      `PMODE_ENERGY: begin
        case (o_power_state)
          PWR_ED_AWAKE: begin
            if (timer_exp) begin
              state_d = PWR_ED_ASLEEP;
            end
          end
          PWR_ED_ASLEEP: begin
            if (host_access) begin
              state_d = PWR_ED_AWAKE;
            end else if (auto_wake_q && timer_exp) begin
              state_d = PWR_ED_AWAKE;
            end
          end
          default: begin
            state_d = PWR_ED_AWAKE;
          end
        endcase
      end
      `PMODE_SAVING: begin
        state_d = PWR_SAVING;
      end
      default: begin
        state_d = PWR_NORMAL;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_power_state <= PWR_NORMAL;
      o_low_power   <= 1'b0;
    end else begin
      o_power_state <= state_d;
      o_low_power   <= (state_d == PWR_ED_ASLEEP);
    end
  end

  // ---------------------------------------------
  // read data path
  // ---------------------------------------------
  logic [`DATA_W-1:0] pm_word;
  logic [`DATA_W-1:0] sw_word;
  logic [`DATA_W-1:0] ctl_word;
  logic [`DATA_W-1:0] stat_word;
  logic [`DATA_W-1:0] pc_word;
  logic [`DATA_W-1:0] ps_word;
  logic [`DATA_W-1:0] rd_word;

  always_comb begin
    pm_word = '0;
    pm_word[`PM_MODE_MSB:`PM_MODE_LSB] = pmode_q;
    pm_word[`PM_AUTO_WAKE] = auto_wake_q;
    sw_word = {wake_q, sleep_q};
    ctl_word = '0;
    ctl_word[`CTL_LOOPBACK]    = o_loopback;
    ctl_word[`CTL_FORCE100]    = o_force_100;
    ctl_word[`CTL_AN_ENABLE]   = o_an_enable;
    ctl_word[`CTL_FULL_DUPLEX] = o_full_duplex;
    ctl_word[`CTL_XOVER_ALG]   = o_xover_alg;
    ctl_word[`CTL_FORCE_MDIX]  = o_force_mdix;
    ctl_word[`CTL_DIS_MDIX]    = o_disable_mdix;
    ctl_word[`CTL_DIS_TX]      = o_tx_disable;
    ctl_word[`CTL_DIS_LED]     = o_led_disable;
    stat_word = '0;
    stat_word[`ST_CAP_MSB:`ST_CAP_LSB] = `ST_CAP_ALL;
    stat_word[`ST_AN_CAP] = 1'b1;
    stat_word[`ST_AN_DONE] = i_an_complete;
    stat_word[`ST_LINK]    = i_link_up;
    pc_word = '0;
    pc_word[`PC_FULL_DUPLEX] = o_full_duplex;
    pc_word[`PC_FORCE100]    = o_force_100;
    pc_word[`PC_AN_ENABLE]   = o_an_enable;
    pc_word[`PC_FORCE_MDIX]  = o_force_mdix;
    pc_word[`PC_DIS_MDIX]    = o_disable_mdix;
    pc_word[`PC_DIS_TX]      = o_tx_disable;
    pc_word[`PC_DIS_LED]     = o_led_disable;
    ps_word = '0;
    ps_word[`PS_XOVER_ALG] = o_xover_alg;
    ps_word[`PS_AN_DONE]   = i_an_complete;
    ps_word[`PS_LINK]      = i_link_up;
  end

  assign rd_word = hit_pm   ? pm_word   :
                   hit_sw   ? sw_word   :
                   hit_ctl  ? ctl_word  :
                   hit_stat ? stat_word :
                   hit_pc   ? pc_word   :
                   hit_ps   ? ps_word   : '0;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rdata  <= i_reg_rd ? rd_word : '0;
      o_reg_rvalid <= i_reg_rd;
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  sequence one_pulse(s);
    s ##1 !s;
  endsequence

  phy_reset_pulse_a: assert property (
    phy_rst_d ##1 !phy_rst_d |-> one_pulse(o_phy_reset))
    else $error("phy reset not a single pulse");

  an_restart_pulse_a: assert property (
    restart_d ##1 !restart_d |-> one_pulse(o_an_restart))
    else $error("autoneg restart not a single pulse");

  host_wake_a: assert property (
    asleep && host_access && pmode_q == `PMODE_ENERGY
    |=> !o_low_power && o_power_state == PWR_ED_AWAKE)
    else $error("host access did not wake");

  wake_gated_a: assert property (
    asleep && !auto_wake_q && !host_access &&
    pmode_q == `PMODE_ENERGY |=> o_low_power)
    else $error("woke without auto wake enable");

  mode_saving_a: assert property (
    pmode_q == `PMODE_SAVING ##1 pmode_q == `PMODE_SAVING
    |-> o_power_state == PWR_SAVING && !o_low_power)
    else $error("power saving state not taken");

  loopback_wr_a: assert property (
    wr_ctl_hi |=> o_loopback == $past(i_reg_wdata[`CTL_LOOPBACK]))
    else $error("loopback bit not stored");

  shared_txdis_a: assert property (
    wr_pc_hi |=> o_tx_disable == $past(i_reg_wdata[`PC_DIS_TX]))
    else $error("shared bit not visible in basic control");

  status_read_a: assert property (
    i_reg_rd && hit_stat |=> o_reg_rvalid && !o_reg_rdata[`ST_T4] &&
    o_reg_rdata[`ST_AN_CAP] && !o_reg_rdata[`ST_EXTENDED] &&
    o_reg_rdata[`ST_CAP_MSB:`ST_CAP_LSB] == `ST_CAP_ALL)
    else $error("capability bits wrong");

  link_mirror_a: assert property (
    i_reg_rd && hit_stat
    |=> o_reg_rdata[`ST_LINK] == $past(i_link_up))
    else $error("link status not mirrored");

  an_done_mirror_a: assert property (
    i_reg_rd && hit_ps
    |=> o_reg_rdata[`PS_AN_DONE] == $past(i_an_complete))
    else $error("autoneg complete not mirrored");
endmodule

// ---- testbench/host_port_model.sv ----
// host side model that drives the register port
`timescale 1ns/1ns
`include "phy_power_regs.svh"
module host_port_model (
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_reg_rdata,
  input  wire logic        i_reg_rvalid,
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic [7:0]       o_reg_addr,
  output logic [15:0]      o_reg_wdata,
  output logic [1:0]       o_reg_be
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 16'h0000;
    o_reg_be = 2'h0;
  end

  // released address and data lines show the inverse of their last value
  task automatic idle();
    o_reg_wr <= 1'b0;
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~o_reg_addr;
    o_reg_wdata <= ~o_reg_wdata;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] be);
    logic [15:0] v;
    v = d;
    if (a == `OFS_PWR_EVENT && v[1:0] == 2'h2)
      v[1:0] = 2'h0;
    if (a == `OFS_SLEEP_WAKE && v[15:8] == 8'h00)
      v[15:8] = 8'h01;
    if (a == `OFS_SLEEP_WAKE && v[7:0] == 8'h00)
      v[7:0] = 8'h01;
    @(posedge i_core_clk);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= v;
    o_reg_be <= be;
    @(posedge i_core_clk);
    idle();
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] q,
                    output logic ok);
    @(posedge i_core_clk);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_core_clk);
    idle();
    q = i_reg_rdata;
    ok = i_reg_rvalid;
  endtask
endmodule

// ---- testbench/phy_power_control_regs_tb.sv ----
// self-checking bench for the phy power control register group
`timescale 1ns/1ns
`include "phy_power_regs.svh"
module phy_power_control_regs_tb;
  import phy_power_pkg::*;
  logic core_clk, resetn, energy, link_up, an_done;
  logic reg_wr, reg_rd, rvalid, rd_ok;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, rdata, rng, d, rd_q, ctl_view;
  logic [1:0] reg_be;
  pwr_state_t pstate;
  logic low_pwr, phy_rst, lpbk, f100, an_en, an_rst, fdx;
  logic xalg, fmdix, dmdix, txdis, leddis;
  int failures, tests_run, cycles;

  assign ctl_view = {1'b0, lpbk, f100, an_en, 3'h0, fdx, 2'h0,
                     xalg, fmdix, dmdix, 1'b0, txdis, leddis};

  phy_power_control_regs #(.MS_CYCLES(4)) dut (
    .i_core_clk(core_clk), .i_resetn(resetn), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_be(reg_be), .i_energy_detect(energy), .i_link_up(link_up),
    .i_an_complete(an_done), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_power_state(pstate), .o_low_power(low_pwr),
    .o_phy_reset(phy_rst), .o_loopback(lpbk), .o_force_100(f100),
    .o_an_enable(an_en), .o_an_restart(an_rst), .o_full_duplex(fdx),
    .o_xover_alg(xalg), .o_force_mdix(fmdix), .o_disable_mdix(dmdix),
    .o_tx_disable(txdis), .o_led_disable(leddis));

  host_port_model host (
    .i_core_clk(core_clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .o_reg_be(reg_be));

  always #4 core_clk = ~core_clk;

  function automatic logic [15:0] xs();
    rng = rng ^ (rng << 7);
    rng = rng ^ (rng >> 9);
    rng = rng ^ (rng << 8);
    return rng;
  endfunction

  function automatic logic [15:0] stat_exp(input logic an, input logic lk);
    return 16'h7808 | {10'h000, an, 2'h0, lk, 2'h0};
  endfunction

  task automatic give_verdict();
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    host.rd(a, rd_q, rd_ok);
    chk_bit(rd_ok, 1'b1);
    chk_word(rd_q, exp);
  endtask

  task automatic wait_lp(input logic want, input int lim);
    for (int i = 0; i < lim && low_pwr !== want; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk_bit(low_pwr, want);
  endtask

  task automatic chk_state(input pwr_state_t s);
    repeat (2) @(posedge core_clk);
    #1;
    chk_word({14'h0000, pstate}, {14'h0000, s});
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    energy = 1'b0;
    link_up = 1'b0;
    an_done = 1'b0;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    rng = 16'h9142;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk_word(ctl_view, 16'h3120);
    rd_chk(`OFS_PWR_EVENT, 16'h0000);
    rd_chk(`OFS_SLEEP_WAKE, 16'h080C);
    rd_chk(`OFS_BASIC_CTL, 16'h3120);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      link_up <= i[0];
      an_done <= i[1];
      rd_chk(`OFS_BASIC_STAT, stat_exp(i[1], i[0]));
    end
    repeat (8) begin
      d = xs();
      host.wr(`OFS_BASIC_CTL, d, 2'h3);
      chk_bit(an_rst, d[9]);
      chk_word(ctl_view, d & 16'h713B);
      rd_chk(`OFS_BASIC_CTL, d & 16'h713B);
    end
    host.wr(`OFS_BASIC_CTL, 16'h0000, 2'h3);
    host.wr(`OFS_BASIC_CTL, 16'hFFFF, 2'h1);
    rd_chk(`OFS_BASIC_CTL, 16'h003B);
    host.wr(`OFS_PORT_CTL, 16'hE000, 2'h3);
    chk_bit(an_rst, 1'b1);
    rd_chk(`OFS_BASIC_CTL, 16'h0023);
    host.wr(`OFS_PORT_STAT, 16'h0000, 2'h2);
    rd_chk(`OFS_BASIC_CTL, 16'h0003);
    rd_chk(`OFS_PORT_CTL, 16'hC000);
    rd_chk(`OFS_PORT_STAT, 16'h0060);
    host.wr(`OFS_PHY_RESET, 16'h0001, 2'h1);
    chk_bit(phy_rst, 1'b1);
    @(posedge core_clk);
    #1;
    chk_bit(phy_rst, 1'b0);
    rd_chk(`OFS_PHY_RESET, 16'h0000);
    host.wr(`OFS_SLEEP_WAKE, 16'h0101, 2'h3);
    host.wr(`OFS_PWR_EVENT, 16'h0003, 2'h3);
    chk_state(PWR_SAVING);
    host.wr(`OFS_PWR_EVENT, 16'h0000, 2'h3);
    chk_state(PWR_NORMAL);
    host.wr(`OFS_PWR_EVENT, 16'h0081, 2'h3);
    chk_state(PWR_ED_AWAKE);
    repeat (3800) @(posedge core_clk);
    #1;
    chk_bit(low_pwr, 1'b0);
    wait_lp(1'b1, 400);
    chk_state(PWR_ED_ASLEEP);
    @(posedge core_clk) energy <= 1'b1;
    repeat (40) @(posedge core_clk);
    #1;
    chk_bit(low_pwr, 1'b1);
    wait_lp(1'b0, 60);
    @(posedge core_clk) energy <= 1'b0;
    wait_lp(1'b1, 4300);
    rd_chk(8'h00, 16'h0000);
    chk_state(PWR_ED_AWAKE);
    host.wr(`OFS_PWR_EVENT, 16'h0001, 2'h3);
    wait_lp(1'b1, 4300);
    @(posedge core_clk) energy <= 1'b1;
    repeat (200) @(posedge core_clk);
    #1;
    chk_bit(low_pwr, 1'b1);
    rd_chk(`OFS_PWR_EVENT, 16'h0001);
    chk_state(PWR_ED_AWAKE);
    give_verdict();
  end
endmodule
